//--- src/adpcm_cfg_pkg.sv
package adpcm_cfg_pkg;

  // Core clock and the engine clock it stands in for
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned ENGINE_MHZ = 10;

  // Pin synchroniser vector layout
  localparam int unsigned PIN_W      = 17;
  localparam int unsigned P_RST_N    = 0;
  localparam int unsigned P_STRAP    = 1;
  localparam int unsigned P_ADDR     = 2;
  localparam int unsigned P_SCLK     = 8;
  localparam int unsigned P_SDI      = 9;
  localparam int unsigned P_CS_N     = 10;
  localparam int unsigned P_SIDE     = 11;
  localparam int unsigned P_SIDE_W   = 3;
  localparam int unsigned P_BCLK     = 0;
  localparam int unsigned P_FS       = 1;
  localparam int unsigned P_DIN      = 2;

  // Side indices
  localparam int unsigned SIDE_X     = 0;
  localparam int unsigned SIDE_Y     = 1;

  // Control byte field positions
  localparam int unsigned IPD_BIT    = 5;
  localparam int unsigned ALRST_BIT  = 4;
  localparam int unsigned BYP_BIT    = 3;
  localparam int unsigned FMT_BIT    = 2;
  localparam int unsigned CPEX_BIT   = 0;
  localparam logic [7:0]  CTRL_RST   = 8'h20;
  localparam logic [7:0]  TS_RST     = 8'h00;

  // Address/command byte layout
  localparam int unsigned ACB_SIDE   = 6;
  localparam logic [1:0]  BYTE_CTRL  = 2'h1;
  localparam logic [1:0]  BYTE_ITS   = 2'h2;
  localparam logic [1:0]  BYTE_OTS   = 2'h3;
  localparam logic [2:0]  BIT_LAST   = 3'h7;

  // Frame bit counter and transmit FIFO depth
  localparam int unsigned CNT_W      = 10;
  localparam logic [2:0]  LAST_BYTE  = 3'h7;
  localparam logic [2:0]  LAST_NIB   = 3'h3;
  localparam int unsigned FIFO_DEPTH = 8;

  // Per-side configuration
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] in_ts;
    logic [7:0] out_ts;
  } side_cfg_t;

  localparam side_cfg_t CFG_RST = '{ctrl: CTRL_RST, in_ts: TS_RST, out_ts: TS_RST};

endpackage

//--- src/sample_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sample_fifo
  import adpcm_cfg_pkg::*;
#(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic [W-1:0]      out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0]  wr_ff;
  logic [AW:0]  rd_ff;
  wire          full  = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  wire          empty = (wr_ff == rd_ff);
  wire          push  = in_valid_i && !full;
  wire          pop   = out_ready_i && !empty;

  // Handshake and head word
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_ff[rd_ff[AW-1:0]];

  // Storage
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
    end
  end

  // Pointers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      wr_ff <= wr_ff + (AW+1)'(push);
      rd_ff <= rd_ff + (AW+1)'(pop);
    end
  end

endmodule
`default_nettype wire

//--- src/adpcm_config_and_pin_mode.sv
// Functional notes
// - Low pulse on reset pin loads reset values into all configuration registers and restarts both algorithms.
// - Reset clears control bits except idle, which is set on both sides.
// - Strap low disables serial port, clears registers, settings come from pins.
// - Hardware mode fixes all input and output timeslots at zero.
// - Hardware mode: address bit 0 codes X, bit 3 codes Y; 1 compresses.
// - Hardware mode: address bit 2 formats X, bit 5 Y; 1 is mu-law.
// - Hardware mode: serial data idles Y, chip select idles X; 1 idles.
// - PCM input sampled on bit clock falling edge, only in input slot.
// - PCM output changes on bit clock rising edge, only in output slot.
// - Engine clock may be asynchronous to serial and PCM clocks.
// - Configuration bits captured on serial clock rising edge.
// - Write accepted only when command address equals strapped address pins.
// - After match, three bytes: control, input slot, output slot; bit 6 picks X.
// - Both sides idle puts device into standby.
// - Slot width is 8 bits when compressing, 4 when expanding.
`timescale 1ns/10ps
`default_nettype none
module adpcm_config_and_pin_mode
  import adpcm_cfg_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       rst_pin_n_i,
  input  wire logic       port_select_strap_i,
  input  wire logic [5:0] dev_addr_i,
  input  wire logic       cfg_port_clock_i,
  input  wire logic       cfg_port_data_i,
  input  wire logic       cfg_port_sel_n_i,
  input  wire logic       side_x_bit_clock_i,
  input  wire logic       side_x_frame_sync_i,
  input  wire logic       side_x_data_in_i,
  output logic            side_x_data_out_o,
  output logic            side_x_data_out_en_o,
  input  wire logic       side_y_bit_clock_i,
  input  wire logic       side_y_frame_sync_i,
  input  wire logic       side_y_data_in_i,
  output logic            side_y_data_out_o,
  output logic            side_y_data_out_en_o,
  input  wire logic [7:0] side_x_tx_data_i,
  input  wire logic       side_x_tx_valid_i,
  output logic            side_x_tx_ready_o,
  input  wire logic [7:0] side_y_tx_data_i,
  input  wire logic       side_y_tx_valid_i,
  output logic            side_y_tx_ready_o,
  output logic [7:0]      side_x_rx_data_o,
  output logic            side_x_rx_valid_o,
  output logic [7:0]      side_y_rx_data_o,
  output logic            side_y_rx_valid_o,
  output side_cfg_t       side_x_cfg_o,
  output side_cfg_t       side_y_cfg_o,
  output logic [1:0]      alg_reset_o,
  output logic            standby_o,
  output logic            hw_mode_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire  [PIN_W-1:0] pins_raw = {side_y_data_in_i, side_y_frame_sync_i, side_y_bit_clock_i,
                                side_x_data_in_i, side_x_frame_sync_i, side_x_bit_clock_i,
                                cfg_port_sel_n_i, cfg_port_data_i, cfg_port_clock_i,
                                dev_addr_i, port_select_strap_i, rst_pin_n_i};
  logic [PIN_W-1:0] sync1_ff;
  logic [PIN_W-1:0] sync2_ff;
  logic [PIN_W-1:0] sync3_ff;

  // Two stages before use, third stage only for edge finding
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // Decoded synchronised pins
  wire       dev_rst  = sys_rst_i || !sync2_ff[P_RST_N];
  wire       strap_s  = sync2_ff[P_STRAP];
  wire [5:0] addr_s   = sync2_ff[P_ADDR +: 6];
  wire       sdi_s    = sync2_ff[P_SDI];
  wire       cs_n_s   = sync2_ff[P_CS_N];
  wire       sclk_up  = sync2_ff[P_SCLK] && !sync3_ff[P_SCLK];
  wire       hw_mode  = !strap_s;

  //////////////////////////////////////////////////////////////////////////////
  // Serial configuration port
  logic [7:0] sp_sh_ff;
  logic [2:0] sp_bit_ff;
  logic [1:0] sp_byte_ff;
  logic       sp_hit_ff;
  logic       sp_side_ff;
  wire        sp_active = strap_s && !cs_n_s;
  wire        sp_take   = sp_active && sclk_up;
  wire  [7:0] nxt_sh    = {sp_sh_ff[6:0], sdi_s};
  wire        byte_done = sp_take && (sp_bit_ff == BIT_LAST);
  wire        acb_done  = byte_done && (sp_byte_ff == 2'h0);
  wire        addr_hit  = (nxt_sh[5:0] == addr_s);
  wire        data_wr   = byte_done && sp_hit_ff && (sp_byte_ff != 2'h0);

  // Bit and byte counting within one chip-select frame
  always_ff @(posedge clock_i) begin
    if (dev_rst || !sp_active) begin
      sp_sh_ff   <= 8'h00;
      sp_bit_ff  <= 3'h0;
      sp_byte_ff <= 2'h0;
      sp_hit_ff  <= 1'b0;
      sp_side_ff <= 1'b0;
    end else if (sp_take) begin
      sp_sh_ff  <= nxt_sh;
      sp_bit_ff <= sp_bit_ff + 3'h1;
      if (byte_done) begin
        sp_byte_ff <= (sp_byte_ff == BYTE_OTS) ? BYTE_OTS : sp_byte_ff + 2'h1;
        sp_hit_ff  <= acb_done ? addr_hit : (sp_hit_ff && sp_byte_ff != BYTE_OTS);
        sp_side_ff <= acb_done ? nxt_sh[ACB_SIDE] : sp_side_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers, one per side
  side_cfg_t  cfg_ff [2];
  wire  [1:0] hw_cpex = {addr_s[3], addr_s[0]};
  wire  [1:0] hw_fmt  = {addr_s[5], addr_s[2]};
  wire  [1:0] hw_ipd  = {sdi_s, cs_n_s};
  logic [1:0] alg_rst_ff;
  logic [1:0] rx_valid_ff;
  logic [7:0] rx_data_ff [2];
  logic [1:0] out_ff;
  logic [1:0] oe_ff;
  wire  [1:0] fifo_ready;
  wire  [1:0] fifo_valid;
  wire  [7:0] fifo_data [2];
  wire  [1:0] fifo_pop;
  wire  [7:0] tx_data [2];
  wire  [1:0] tx_valid = {side_y_tx_valid_i, side_x_tx_valid_i};

  assign tx_data[SIDE_X] = side_x_tx_data_i;
  assign tx_data[SIDE_Y] = side_y_tx_data_i;

  for (genvar s = 0; s < 2; s++) begin : g_side
    wire       sel_wr = data_wr && (sp_side_ff == (s == SIDE_X));
    wire       cpex   = cfg_ff[s].ctrl[CPEX_BIT];
    wire       idle_power_down    = cfg_ff[s].ctrl[IPD_BIT];
    wire [7:0] hw_ctrl = {2'b00, hw_ipd[s], 2'b00, hw_fmt[s], 1'b0, hw_cpex[s]};

    // Reset, pin mapping in hardware mode, serial writes otherwise
    always_ff @(posedge clock_i) begin
      if (dev_rst) begin
        cfg_ff[s] <= CFG_RST;
      end else if (hw_mode) begin
        cfg_ff[s] <= '{ctrl: hw_ctrl, in_ts: TS_RST, out_ts: TS_RST};
      end else if (sel_wr && sp_byte_ff == BYTE_CTRL) begin
        cfg_ff[s].ctrl <= nxt_sh;
      end else if (sel_wr && sp_byte_ff == BYTE_ITS) begin
        cfg_ff[s].in_ts <= nxt_sh;
      end else if (sel_wr && sp_byte_ff == BYTE_OTS) begin
        cfg_ff[s].out_ts <= nxt_sh;
      end else begin
        cfg_ff[s].ctrl[ALRST_BIT] <= 1'b0;                  // Self-clearing
      end
    end

    // Algorithm restart request for the engine
    always_ff @(posedge clock_i) begin
      alg_rst_ff[s] <= dev_rst || cfg_ff[s].ctrl[ALRST_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // PCM side framing
    wire             bclk_q  = sync2_ff[P_SIDE + s*P_SIDE_W + P_BCLK];
    wire             bclk_qq = sync3_ff[P_SIDE + s*P_SIDE_W + P_BCLK];
    wire             fs_s    = sync2_ff[P_SIDE + s*P_SIDE_W + P_FS];
    wire             din_s   = sync2_ff[P_SIDE + s*P_SIDE_W + P_DIN];
    wire             rise    = bclk_q && !bclk_qq;
    wire             fall    = !bclk_q && bclk_qq;
    logic [CNT_W-1:0] cnt_ff;
    logic [7:0]      rx_sh_ff;
    logic [7:0]      tx_sh_ff;
    wire [CNT_W-1:0] nxt_cnt = fs_s ? '0 : ((&cnt_ff) ? cnt_ff : cnt_ff + 1'b1);

    // Slot decode, 8-bit or 4-bit slots
    wire [7:0] slot_c = cpex ? {1'b0, cnt_ff[9:3]} : cnt_ff[9:2];
    wire [2:0] pos_c  = cpex ? cnt_ff[2:0] : {1'b0, cnt_ff[1:0]};
    wire [7:0] slot_n = cpex ? {1'b0, nxt_cnt[9:3]} : nxt_cnt[9:2];
    wire [2:0] pos_n  = cpex ? nxt_cnt[2:0] : {1'b0, nxt_cnt[1:0]};
    wire       last_c = (pos_c == (cpex ? LAST_BYTE : LAST_NIB));
    wire       in_win = fall && !idle_power_down && (slot_c == cfg_ff[s].in_ts);
    wire       o_win  = !idle_power_down && (slot_n == cfg_ff[s].out_ts);
    wire       first  = (pos_n == 3'h0);
    wire [7:0] ld     = fifo_valid[s] ? fifo_data[s] : 8'h00;
    wire [7:0] new_sh = first ? ld : {tx_sh_ff[6:0], 1'b0};
    wire [7:0] rx_w   = {rx_sh_ff[6:0], din_s};

    assign fifo_pop[s] = rise && o_win && first;

    // Bit counter restarts at the frame sync seen on a rising edge
    always_ff @(posedge clock_i) begin
      if (dev_rst) begin
        cnt_ff <= '1;
      end else if (rise) begin
        cnt_ff <= nxt_cnt;
      end
    end

    // Receive shift and word hand-off
    always_ff @(posedge clock_i) begin
      if (dev_rst) begin
        rx_sh_ff       <= 8'h00;
        rx_data_ff[s]  <= 8'h00;
        rx_valid_ff[s] <= 1'b0;
      end else begin
        rx_valid_ff[s] <= in_win && last_c;
        if (in_win) begin
          rx_sh_ff <= rx_w;
        end
        if (in_win && last_c) begin
          rx_data_ff[s] <= cpex ? rx_w : {4'h0, rx_w[3:0]};
        end
      end
    end

    // Transmit shift, driven only inside the output slot
    always_ff @(posedge clock_i) begin
      if (dev_rst) begin
        tx_sh_ff  <= 8'h00;
        out_ff[s] <= 1'b0;
        oe_ff[s]  <= 1'b0;
      end else if (rise) begin
        oe_ff[s] <= o_win;
        if (o_win) begin
          tx_sh_ff  <= new_sh;
          out_ff[s] <= cpex ? new_sh[7] : new_sh[3];
        end
      end
    end

    sample_fifo #(
      .W     (8),
      .DEPTH (DEPTH)
    ) u_fifo (
      .clock_i     (clock_i),
      .sys_rst_i   (dev_rst),
      .in_data_i   (tx_data[s]),
      .in_valid_i  (tx_valid[s]),
      .in_ready_o  (fifo_ready[s]),
      .out_data_o  (fifo_data[s]),
      .out_valid_o (fifo_valid[s]),
      .out_ready_i (fifo_pop[s])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign side_x_data_out_o    = out_ff[SIDE_X];
  assign side_y_data_out_o    = out_ff[SIDE_Y];
  assign side_x_data_out_en_o = oe_ff[SIDE_X] && !cfg_ff[SIDE_X].ctrl[IPD_BIT];
  assign side_y_data_out_en_o = oe_ff[SIDE_Y] && !cfg_ff[SIDE_Y].ctrl[IPD_BIT];
  assign side_x_tx_ready_o    = fifo_ready[SIDE_X];
  assign side_y_tx_ready_o    = fifo_ready[SIDE_Y];
  assign side_x_rx_data_o     = rx_data_ff[SIDE_X];
  assign side_y_rx_data_o     = rx_data_ff[SIDE_Y];
  assign side_x_rx_valid_o    = rx_valid_ff[SIDE_X];
  assign side_y_rx_valid_o    = rx_valid_ff[SIDE_Y];
  assign side_x_cfg_o         = cfg_ff[SIDE_X];
  assign side_y_cfg_o         = cfg_ff[SIDE_Y];
  assign alg_reset_o          = alg_rst_ff;
  assign hw_mode_o            = hw_mode;
  // Low-power standby when both sides idle
  assign standby_o = cfg_ff[SIDE_X].ctrl[IPD_BIT] && cfg_ff[SIDE_Y].ctrl[IPD_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_reset_idle_set: assert property (dev_rst |=> cfg_ff[0] == CFG_RST && cfg_ff[1] == CFG_RST)
    else $error("reset did not leave both sides idle");
  a_reset_alg_pulse: assert property (dev_rst |=> alg_reset_o == 2'b11)
    else $error("algorithm reset not raised by device reset");
  a_hw_slots_zero: assert property (!dev_rst && hw_mode |=>
      cfg_ff[0].in_ts == 8'h00 && cfg_ff[0].out_ts == 8'h00 &&
      cfg_ff[1].in_ts == 8'h00 && cfg_ff[1].out_ts == 8'h00)
    else $error("hardware mode timeslot not zero");
  a_hw_pin_map: assert property (!dev_rst && hw_mode |=>
      cfg_ff[0].ctrl[CPEX_BIT] == $past(addr_s[0]) && cfg_ff[1].ctrl[FMT_BIT] == $past(addr_s[5]))
    else $error("hardware mode pin map wrong");
  a_hw_idle_map: assert property (!dev_rst && hw_mode |=>
      cfg_ff[0].ctrl[IPD_BIT] == $past(cs_n_s) && cfg_ff[1].ctrl[IPD_BIT] == $past(sdi_s))
    else $error("hardware mode idle map wrong");
  a_cs_high_hold: assert property (!dev_rst && strap_s && cs_n_s |=> $stable(cfg_ff[0].in_ts))
    else $error("configuration changed without chip select");
  a_miss_no_write: assert property (acb_done && !addr_hit |=> !sp_hit_ff)
    else $error("mismatched address accepted");
  a_out_on_rise: assert property ($changed(side_x_data_out_o) |-> $past(g_side[0].rise) || $past(dev_rst))
    else $error("output changed off a rising edge");
  a_rx_on_fall: assert property (side_y_rx_valid_o |-> $past(g_side[1].fall))
    else $error("receive word not on falling edge");
  a_idle_no_drive: assert property (cfg_ff[0].ctrl[IPD_BIT] |-> !side_x_data_out_en_o)
    else $error("idle side drives output");

  c_serial_hit: cover property (acb_done && addr_hit ##[1:600] data_wr);
  c_rx_word: cover property (side_x_rx_valid_o);
  c_standby_exit: cover property (standby_o ##1 !standby_o);
  c_fifo_full: cover property (!side_x_tx_ready_o);

endmodule
`default_nettype wire

//--- verification/pcm_side_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far end of one PCM side: backplane clock, frame sync and serial data
module pcm_side_model (
  output logic     bclk_o,
  output logic     fs_o,
  output logic     din_o,
  input  wire logic dout_i
);
  // Frame period of an 8 kHz sync
  localparam int FRAME_NS = 125000;

  initial begin
    bclk_o = 1'b0;
    fs_o   = 1'b0;
    din_o  = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One 16-bit frame; the bit clock stands still outside it
  task automatic frame(input logic [7:0] tx, input int w, output logic [7:0] rx);
    rx = 8'h00;
    #37;
    for (int b = 0; b < 16; b++) begin
      // Sync is raised ahead of the first rise and dropped before the second
      fs_o = (b == 0);
      #50;
      bclk_o = 1'b1;
      // Slot bits MSB first, a toggling pattern outside the slot
      din_o = (b < w) ? tx[w-1-b] : ~din_o;
      #100;
      bclk_o = 1'b0;
      #50;
      if (b < w) begin
        rx[w-1-b] = dout_i;
      end
    end
    fs_o = 1'b0;
    // Clock stands still for the rest of the frame period
    #(FRAME_NS - 37 - 16 * 200);
  endtask
endmodule
`default_nettype wire

//--- verification/adpcm_config_and_pin_mode_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adpcm_config_and_pin_mode_bench;
  import adpcm_cfg_pkg::*;
  localparam logic [5:0] ADDR = 6'h2D;
  logic       clock_i, sys_rst_i, rst_pin_n, strap, sclk, cfg_port_data, cs_n;
  logic [5:0] addr;
  logic       xb, xf, xd, xo, xe, yb, yf, yd, yo, ye;
  logic [7:0] xtd, ytd, xrd, yrd;
  logic       xtv, ytv, xtr, ytr, xrv, yrv, standby, hw;
  logic [1:0] alrst;
  logic       en_seen;
  side_cfg_t  xcfg, ycfg;
  int         failures, n_tests;

  adpcm_config_and_pin_mode dut_u (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .rst_pin_n_i(rst_pin_n), .port_select_strap_i(strap),
    .dev_addr_i(addr), .cfg_port_clock_i(sclk), .cfg_port_data_i(cfg_port_data), .cfg_port_sel_n_i(cs_n),
    .side_x_bit_clock_i(xb), .side_x_frame_sync_i(xf), .side_x_data_in_i(xd), .side_x_data_out_o(xo),
    .side_x_data_out_en_o(xe), .side_y_bit_clock_i(yb), .side_y_frame_sync_i(yf), .side_y_data_in_i(yd),
    .side_y_data_out_o(yo), .side_y_data_out_en_o(ye), .side_x_tx_data_i(xtd), .side_x_tx_valid_i(xtv),
    .side_x_tx_ready_o(xtr), .side_y_tx_data_i(ytd), .side_y_tx_valid_i(ytv), .side_y_tx_ready_o(ytr),
    .side_x_rx_data_o(xrd), .side_x_rx_valid_o(xrv), .side_y_rx_data_o(yrd), .side_y_rx_valid_o(yrv),
    .side_x_cfg_o(xcfg), .side_y_cfg_o(ycfg), .alg_reset_o(alrst), .standby_o(standby), .hw_mode_o(hw)
  );
  pcm_side_model model_x_u (.bclk_o(xb), .fs_o(xf), .din_o(xd), .dout_i(xo));
  pcm_side_model model_y_u (.bclk_o(yb), .fs_o(yf), .din_o(yd), .dout_i(yo));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp_cfg(input string what, input side_cfg_t exp, input side_cfg_t got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Whole write with chip select low throughout, MSB first
  task automatic ser_write(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                           input logic [7:0] b3);
    logic [31:0] w;
    w = {b0, b1, b2, b3};
    cs_n = 1'b0;
    tick(4);
    for (int i = 31; i >= 0; i--) begin
      cfg_port_data = w[i];
      tick(4);
      sclk = 1'b1;
      tick(4);
      sclk = 1'b0;
    end
    tick(4);
    cs_n = 1'b1;
    tick(4);
  endtask
  task automatic pin_reset;
    rst_pin_n = 1'b0;
    tick(10);
    cmp_val("alg reset", 8'h03, {6'h00, alrst});
    rst_pin_n = 1'b1;
    tick(8);
  endtask
  task automatic push(input logic [7:0] d);
    xtd = d;
    xtv = 1'b1;
    tick(1);
    xtv = 1'b0;
    tick(1);
  endtask
  // One frame on a side, catching the received word under a bound
  task automatic run_frame(input int side, input logic [7:0] tx, input int w, output logic [7:0] seen,
                           output logic [7:0] got);
    int k;
    got = 8'hEE;
    en_seen = 1'b0;
    fork
      if (side == 0) model_x_u.frame(tx, w, seen);
      else model_y_u.frame(tx, w, seen);
      begin
        for (k = 0; k < 400; k++) begin
          @(posedge clock_i);
          #1;
          if ((side == 0 ? xrv : yrv) === 1'b1) begin
            got = (side == 0) ? xrd : yrd;
            en_seen = (side == 0) ? xe : ye;
            break;
          end
        end
        if (k == 400) begin
          failures++;
          $display("unexpected rx_valid timeout expected 1 seen 0");
          end_sim();
        end
      end
    join
    tick(4);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    cmp_cfg("x cfg", CFG_RST, xcfg);
    cmp_cfg("y cfg", CFG_RST, ycfg);
    cmp_val("standby", 8'h01, {7'h00, standby});
    cmp_val("alg reset", 8'h00, {6'h00, alrst});
    $display("test reset done");
  endtask
  task automatic t_serial;
    ser_write({2'b01, ADDR}, 8'h05, 8'h01, 8'h02);
    cmp_cfg("x cfg", '{ctrl: 8'h05, in_ts: 8'h01, out_ts: 8'h02}, xcfg);
    cmp_cfg("y cfg", CFG_RST, ycfg);
    cmp_val("standby", 8'h00, {7'h00, standby});
    ser_write({2'b00, ADDR}, 8'h24, 8'h03, 8'h04);
    cmp_cfg("y cfg", '{ctrl: 8'h24, in_ts: 8'h03, out_ts: 8'h04}, ycfg);
    ser_write({2'b01, ADDR ^ 6'h20}, 8'h20, 8'h07, 8'h07);
    cmp_cfg("x cfg", '{ctrl: 8'h05, in_ts: 8'h01, out_ts: 8'h02}, xcfg);
    pin_reset();
    cmp_cfg("x cfg", CFG_RST, xcfg);
    cmp_cfg("y cfg", CFG_RST, ycfg);
    $display("test serial done");
  endtask
  task automatic t_hw_map;
    logic [3:0] i;
    strap = 1'b0;
    pin_reset();
    for (i = 0; i < 4; i++) begin
      // Address bits 1 and 4 and the serial clock stay low
      addr = {~i[1], 1'b0, ~i[0], i[1], 1'b0, i[0]};
      cs_n = i[0];
      cfg_port_data = i[1];
      tick(8);
      cmp_cfg("x cfg", '{ctrl: {2'b00, i[0], 2'b00, i[1], 1'b0, i[0]}, in_ts: 8'h00, out_ts: 8'h00}, xcfg);
      cmp_cfg("y cfg", '{ctrl: {2'b00, i[1], 2'b00, ~i[1], 1'b0, ~i[0]}, in_ts: 8'h00, out_ts: 8'h00}, ycfg);
      cmp_val("standby", {7'h00, i[0] & i[1]}, {7'h00, standby});
      cmp_val("hw mode", 8'h01, {7'h00, hw});
    end
    $display("test hardware map done");
  endtask
  task automatic t_pcm;
    logic [7:0] seen, got;
    addr = 6'h01;
    cs_n = 1'b0;
    cfg_port_data = 1'b0;
    tick(8);
    for (int i = 0; i < 8; i++) begin
      push(8'h5A ^ {i[3:0], i[3:0]});
    end
    cmp_val("x tx ready", 8'h00, {7'h00, xtr});
    for (int i = 0; i < 8; i++) begin
      run_frame(0, ~(8'h5A ^ {i[3:0], i[3:0]}), 8, seen, got);
      cmp_val("x out word", 8'h5A ^ {i[3:0], i[3:0]}, seen);
      cmp_val("x in word", ~(8'h5A ^ {i[3:0], i[3:0]}), got);
      cmp_val("x out en", 8'h01, {7'h00, en_seen});
    end
    cmp_val("x tx ready", 8'h01, {7'h00, xtr});
    cmp_val("x out en off", 8'h00, {7'h00, xe});
    run_frame(0, 8'h33, 8, seen, got);
    cmp_val("x empty word", 8'h00, seen);
    ytd = 8'h0B;
    ytv = 1'b1;
    tick(1);
    ytv = 1'b0;
    run_frame(1, 8'h06, 4, seen, got);
    cmp_val("y out nibble", 8'h0B, seen);
    cmp_val("y in nibble", 8'h06, {4'h0, got[3:0]});
    cmp_val("y out en", 8'h01, {7'h00, en_seen});
    cmp_val("y tx ready", 8'h01, {7'h00, ytr});
    $display("test pcm done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock and main sequence
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    failures = 0;
    n_tests = 0;
    sys_rst_i = 1'b1;
    rst_pin_n = 1'b0;
    strap = 1'b1;
    addr = ADDR;
    sclk = 1'b0;
    cfg_port_data = 1'b0;
    cs_n = 1'b1;
    xtd = 8'h00;
    ytd = 8'h00;
    xtv = 1'b0;
    ytv = 1'b0;
    tick(20);
    sys_rst_i = 1'b0;
    // Power-up pin reset of 1 ms at 40 MHz
    tick(40000);
    rst_pin_n = 1'b1;
    tick(8);
    t_reset();
    t_serial();
    t_hw_map();
    t_pcm();
    end_sim();
  end
endmodule
`default_nettype wire
